// ==== core/pmlr_cmp.sv ====
`timescale 1ns/10ps
`include "pmlr_map.svh"

// Threshold comparators, purely combinational; the caller decides when to sample
module pmlr_cmp #(
  parameter int PWR_W = 24
) (
  input wire logic [15:0] shunt_meas_i,
  input wire logic [15:0] bus_meas_i,
  input wire logic [11:0] heat_meas_i,
  input wire logic [PWR_W-1:0] power_meas_i,
  input wire logic [15:0] shunt_high_level_i,
  input wire logic [15:0] shunt_low_level_i,
  input wire logic [14:0] bus_high_level_i,
  input wire logic [14:0] bus_low_level_i,
  input wire logic [11:0] heat_high_level_i,
  input wire logic [15:0] watt_high_level_i,
  output logic [5:0] hits_o
);

  // Signed greater-than on 16-bit words
  function automatic logic sgt(input logic [15:0] a, input logic [15:0] b);
    sgt = $signed(a) > $signed(b);
  endfunction

  // Unsigned greater-than on 32-bit words
  function automatic logic ugt(input logic [31:0] a, input logic [31:0] b);
    ugt = a > b;
  endfunction

  wire [15:0] heat_meas_ext; // Sign-extended die reading
  wire [15:0] heat_thr_ext; // Sign-extended threshold field
  wire [31:0] power_ext; // Power result widened for comparison
  wire [31:0] watt_thr_ext; // Threshold scaled to power steps

  assign heat_meas_ext = {{4{heat_meas_i[11]}}, heat_meas_i};
  assign heat_thr_ext = {{4{heat_high_level_i[11]}}, heat_high_level_i};
  assign power_ext = 32'(power_meas_i);
  assign watt_thr_ext = {8'h00, watt_high_level_i, 8'h00};

  // Signed for shunt and heat, a negative over level trips at zero
  assign hits_o[5] = sgt(heat_meas_ext, heat_thr_ext);
  assign hits_o[4] = sgt(shunt_meas_i, shunt_high_level_i);
  assign hits_o[3] = sgt(shunt_low_level_i, shunt_meas_i);
  // Unsigned for bus and power; the bus field is zero-extended to 32 bits
  assign hits_o[2] = ugt({16'h0000, bus_meas_i}, {17'h00000, bus_high_level_i});
  assign hits_o[1] = ugt({17'h00000, bus_low_level_i}, {16'h0000, bus_meas_i});
  assign hits_o[0] = ugt(power_ext, watt_thr_ext);

endmodule

// ==== core/pmlr_map.svh ====
`ifndef PMLR_MAP_SVH
`define PMLR_MAP_SVH

// Register offsets on the parallel register port
`define PMLR_ADDR_DIAG 8'h0B
`define PMLR_ADDR_SHUNT_HI 8'h0C
`define PMLR_ADDR_SHUNT_LO 8'h0D
`define PMLR_ADDR_BUS_HI 8'h0E
`define PMLR_ADDR_BUS_LO 8'h0F
`define PMLR_ADDR_HEAT_HI 8'h10
`define PMLR_ADDR_WATT_HI 8'h11
`define PMLR_ADDR_MAKER 8'h3E

// Power-on values of the threshold fields
`define PMLR_RST_SHUNT_HI 16'h7FFF
`define PMLR_RST_SHUNT_LO 16'h8000
`define PMLR_RST_BUS_HI 15'h7FFF
`define PMLR_RST_BUS_LO 15'h0000
`define PMLR_RST_HEAT_HI 12'h7FF
`define PMLR_RST_WATT_HI 16'hFFFF

// Field positions in the threshold words
`define PMLR_BUS_FIELD_MSB 14
`define PMLR_HEAT_FIELD_LSB 4

// Bit positions in the diagnostic flag word
`define PMLR_BIT_HEAT_HI 7
`define PMLR_BIT_SHUNT_HI 6
`define PMLR_BIT_SHUNT_LO 5
`define PMLR_BIT_BUS_HI 4
`define PMLR_BIT_BUS_LO 3
`define PMLR_BIT_WATT_HI 2
`define PMLR_BIT_CONV_DONE 1
`define PMLR_BIT_TRIM_OK 0

// Shunt step weight in nanovolts for each range
`define PMLR_STEP_WIDE_NV 16'h1388
`define PMLR_STEP_NARROW_NV 16'h04E2

// Power threshold step counts 256 power steps
`define PMLR_WATT_SCALE_SHIFT 8

`endif

// ==== core/pmlr_pkg.sv ====
package pmlr_pkg;

  // Register selected by the current address
  typedef enum logic [3:0] {
    REG_NONE = 4'b0000,
    REG_DIAG = 4'b0001,
    REG_SHUNT_HI = 4'b0010,
    REG_SHUNT_LO = 4'b0011,
    REG_BUS_HI = 4'b0100,
    REG_BUS_LO = 4'b0101,
    REG_HEAT_HI = 4'b0110,
    REG_WATT_HI = 4'b0111,
    REG_MAKER = 4'b1000
  } pmlr_reg_t;

  // One register word
  typedef logic [15:0] pmlr_word_t;

endpackage

// ==== core/pmlr_top.sv ====
`timescale 1ns/10ps
`include "pmlr_map.svh"

module pmlr_top #(
  parameter int PWR_W = 24,
  parameter logic [15:0] MAKER_CODE = 16'h4142 // Arbitrary neutral value
) (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic CE_I,
  input wire logic [7:0] REG_ADDR_I,
  input wire logic [15:0] REG_WDATA_I,
  input wire logic REG_WR_I,
  input wire logic REG_RD_I,
  output logic [15:0] REG_RDATA_O,
  input wire logic MEAS_VALID_I,
  input wire logic [15:0] SHUNT_MEAS_I,
  input wire logic [15:0] BUS_MEAS_I,
  input wire logic [11:0] DIE_HEAT_READING_I,
  input wire logic [PWR_W-1:0] POWER_MEAS_I,
  input wire logic SHUNT_RANGE_SELECT_I,
  input wire logic ALERT_LATCH_MODE_I,
  input wire logic TRIM_CSUM_ERR_I,
  output logic [7:0] DIAG_FLAGS_O,
  output logic [15:0] SHUNT_STEP_NV_O
);

  // Power must hold a full scaled threshold and fit the comparator word
  if (PWR_W < 24 || PWR_W > 32) begin : g_bad_pwr_w
    $error("PWR_W must lie between 24 and 32");
  end

  // Map an address onto a register selector
  function automatic pmlr_pkg::pmlr_reg_t reg_decode(input logic [7:0] addr);
    case (addr)
      `PMLR_ADDR_DIAG: reg_decode = pmlr_pkg::REG_DIAG;
      `PMLR_ADDR_SHUNT_HI: reg_decode = pmlr_pkg::REG_SHUNT_HI;
      `PMLR_ADDR_SHUNT_LO: reg_decode = pmlr_pkg::REG_SHUNT_LO;
      `PMLR_ADDR_BUS_HI: reg_decode = pmlr_pkg::REG_BUS_HI;
      `PMLR_ADDR_BUS_LO: reg_decode = pmlr_pkg::REG_BUS_LO;
      `PMLR_ADDR_HEAT_HI: reg_decode = pmlr_pkg::REG_HEAT_HI;
      `PMLR_ADDR_WATT_HI: reg_decode = pmlr_pkg::REG_WATT_HI;
      `PMLR_ADDR_MAKER: reg_decode = pmlr_pkg::REG_MAKER;
      default: reg_decode = pmlr_pkg::REG_NONE;
    endcase
  endfunction

  // Threshold storage
  logic [15:0] shunt_high_level_r; // Signed shunt over level
  logic [15:0] shunt_low_level_r; // Signed shunt under level
  logic [14:0] bus_high_level_r; // Unsigned bus over level
  logic [14:0] bus_low_level_r; // Unsigned bus under level
  logic [11:0] heat_high_level_r; // Signed die heat over level
  logic [15:0] watt_high_level_r; // Unsigned power over level

  // Status storage
  logic [5:0] limit_flags_r; // Heat, shunt hi/lo, bus hi/lo, power
  logic [5:0] limit_flags_nxt;
  logic conv_done_r; // New result seen since last flag read
  logic trim_ok_r; // Trim memory passed its checksum
  logic [15:0] rdata_r; // Read data holding register
  logic [15:0] step_r; // Shunt step weight in nanovolts

  // Decode and strobes
  pmlr_pkg::pmlr_reg_t reg_sel; // Addressed register
  wire wr_en; // Write taken this cycle
  wire rd_en; // Read taken this cycle
  wire meas_take; // New measurement result taken
  wire diag_rd; // Flag register read
  wire limit_clear; // Latched flags cleared by the read
  wire [5:0] cmp_hits; // Live comparison results
  wire [15:0] diag_word; // Flag register as read
  logic [15:0] rd_word; // Selected read value

  assign reg_sel = reg_decode(REG_ADDR_I);
  assign wr_en = CE_I & REG_WR_I;
  assign rd_en = CE_I & REG_RD_I;
  assign meas_take = CE_I & MEAS_VALID_I;
  assign diag_rd = rd_en & (reg_sel == pmlr_pkg::REG_DIAG);
  assign limit_clear = diag_rd & ALERT_LATCH_MODE_I;

  // Comparators see the stored levels and the live result
  pmlr_cmp #(
    .PWR_W(PWR_W)
  ) u_cmp (
    .shunt_meas_i(SHUNT_MEAS_I),
    .bus_meas_i(BUS_MEAS_I),
    .heat_meas_i(DIE_HEAT_READING_I),
    .power_meas_i(POWER_MEAS_I),
    .shunt_high_level_i(shunt_high_level_r),
    .shunt_low_level_i(shunt_low_level_r),
    .bus_high_level_i(bus_high_level_r),
    .bus_low_level_i(bus_low_level_r),
    .heat_high_level_i(heat_high_level_r),
    .watt_high_level_i(watt_high_level_r),
    .hits_o(cmp_hits)
  );

  // Latched mode keeps hits until read; a new hit beats the read clear
  // Transparent mode takes each new comparison as it comes
  assign limit_flags_nxt = ALERT_LATCH_MODE_I ?
    ((limit_flags_r & ~{6{limit_clear}}) | (cmp_hits & {6{meas_take}})) :
    (meas_take ? cmp_hits : limit_flags_r);

  // Flag word laid out in its documented bit order
  assign diag_word = {8'h00,
                      limit_flags_r[5], limit_flags_r[4], limit_flags_r[3],
                      limit_flags_r[2], limit_flags_r[1], limit_flags_r[0],
                      conv_done_r, trim_ok_r};

  // Read mux; unmapped addresses read as zero
  always_comb begin
    case (reg_sel)
      pmlr_pkg::REG_DIAG: rd_word = diag_word;
      pmlr_pkg::REG_SHUNT_HI: rd_word = shunt_high_level_r;
      pmlr_pkg::REG_SHUNT_LO: rd_word = shunt_low_level_r;
      pmlr_pkg::REG_BUS_HI: rd_word = {1'b0, bus_high_level_r};
      pmlr_pkg::REG_BUS_LO: rd_word = {1'b0, bus_low_level_r};
      pmlr_pkg::REG_HEAT_HI: rd_word = {heat_high_level_r, 4'h0};
      pmlr_pkg::REG_WATT_HI: rd_word = watt_high_level_r;
      pmlr_pkg::REG_MAKER: rd_word = MAKER_CODE;
      default: rd_word = 16'h0000;
    endcase
  end

  // Shunt levels, two's complement words
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      shunt_high_level_r <= `PMLR_RST_SHUNT_HI;
      shunt_low_level_r <= `PMLR_RST_SHUNT_LO;
    end else if (wr_en) begin
      if (reg_sel == pmlr_pkg::REG_SHUNT_HI) begin
        shunt_high_level_r <= REG_WDATA_I;
      end
      if (reg_sel == pmlr_pkg::REG_SHUNT_LO) begin
        shunt_low_level_r <= REG_WDATA_I;
      end
    end
  end

  // Bus levels; the reserved top bit is dropped on write
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      bus_high_level_r <= `PMLR_RST_BUS_HI;
      bus_low_level_r <= `PMLR_RST_BUS_LO;
    end else if (wr_en) begin
      if (reg_sel == pmlr_pkg::REG_BUS_HI) begin
        bus_high_level_r <= REG_WDATA_I[`PMLR_BUS_FIELD_MSB:0];
      end
      if (reg_sel == pmlr_pkg::REG_BUS_LO) begin
        bus_low_level_r <= REG_WDATA_I[`PMLR_BUS_FIELD_MSB:0];
      end
    end
  end

  // Heat and power levels; the heat low nibble is never stored
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      heat_high_level_r <= `PMLR_RST_HEAT_HI;
      watt_high_level_r <= `PMLR_RST_WATT_HI;
    end else if (wr_en) begin
      if (reg_sel == pmlr_pkg::REG_HEAT_HI) begin
        heat_high_level_r <= REG_WDATA_I[15:`PMLR_HEAT_FIELD_LSB];
      end
      if (reg_sel == pmlr_pkg::REG_WATT_HI) begin
        watt_high_level_r <= REG_WDATA_I;
      end
    end
  end

  // Limit flags; a write to the flag word is ignored so software cannot fake a trip
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      limit_flags_r <= 6'h00;
    end else if (CE_I) begin
      limit_flags_r <= limit_flags_nxt;
    end
  end

  // Conversion-done flag; a result arriving with the read still sets it
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      conv_done_r <= 1'b0;
    end else if (CE_I) begin
      conv_done_r <= meas_take | (conv_done_r & ~diag_rd);
    end
  end

  // Trim-ok stays low once a checksum error is seen, until reset
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      trim_ok_r <= 1'b1;
    end else if (CE_I && TRIM_CSUM_ERR_I) begin
      trim_ok_r <= 1'b0;
    end
  end

  // Read data is captured on the read strobe, before any clear lands
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_r <= 16'h0000;
    end else if (rd_en) begin
      rdata_r <= rd_word;
    end
  end

  // Step weight of shunt result and level; both share it, so compares stay raw
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      step_r <= `PMLR_STEP_WIDE_NV;
    end else if (CE_I) begin
      step_r <= SHUNT_RANGE_SELECT_I ? `PMLR_STEP_NARROW_NV : `PMLR_STEP_WIDE_NV;
    end
  end

  assign REG_RDATA_O = rdata_r;
  assign DIAG_FLAGS_O = diag_word[7:0];
  assign SHUNT_STEP_NV_O = step_r;

  // Checks on the design's outputs and internal registers
  default clocking cb @(posedge SYS_CLK_I);
  endclocking
  default disable iff (RST_I);

  chk_trim_stays_low: assert property (
    !trim_ok_r |=> !DIAG_FLAGS_O[`PMLR_BIT_TRIM_OK])
    else $error("trim-ok bit rose again without reset");

  chk_trim_error_drop: assert property (
    CE_I && TRIM_CSUM_ERR_I |=> !DIAG_FLAGS_O[`PMLR_BIT_TRIM_OK] [*3])
    else $error("trim-ok bit did not fall after checksum error");

  chk_neg_over_zero: assert property (
    meas_take && shunt_high_level_r[15] && SHUNT_MEAS_I == 16'h0000
    |=> DIAG_FLAGS_O[`PMLR_BIT_SHUNT_HI])
    else $error("zero shunt did not trip negative over level");

  chk_shunt_over_flag: assert property (
    meas_take && $signed(SHUNT_MEAS_I) > $signed(shunt_high_level_r)
    |=> DIAG_FLAGS_O[`PMLR_BIT_SHUNT_HI])
    else $error("shunt over flag missing");

  chk_bus_top_zero: assert property (
    rd_en && (reg_sel == pmlr_pkg::REG_BUS_HI || reg_sel == pmlr_pkg::REG_BUS_LO)
    |=> REG_RDATA_O[15] == 1'b0)
    else $error("bus level top bit read as one");

  chk_heat_nibble_zero: assert property (
    rd_en && reg_sel == pmlr_pkg::REG_HEAT_HI |=> REG_RDATA_O[3:0] == 4'h0)
    else $error("heat level low nibble not zero");

  chk_maker_code_read: assert property (
    rd_en && reg_sel == pmlr_pkg::REG_MAKER |=> REG_RDATA_O == MAKER_CODE)
    else $error("maker code read back wrong");

  chk_latch_hold: assert property (
    CE_I && ALERT_LATCH_MODE_I && DIAG_FLAGS_O[`PMLR_BIT_HEAT_HI] && !diag_rd
    |=> DIAG_FLAGS_O[`PMLR_BIT_HEAT_HI])
    else $error("latched heat flag dropped without a read");

  chk_latch_read_clear: assert property (
    ALERT_LATCH_MODE_I && diag_rd && !meas_take
    |=> DIAG_FLAGS_O[7:2] == 6'h00)
    else $error("latched flags survived a flag read");

  chk_watt_scaled: assert property (
    meas_take && 32'(POWER_MEAS_I) > {8'h00, watt_high_level_r, 8'h00}
    |=> DIAG_FLAGS_O[`PMLR_BIT_WATT_HI])
    else $error("power over flag missing");

  chk_bus_under_flag: assert property (
    meas_take && BUS_MEAS_I < {1'b0, bus_low_level_r}
    |=> DIAG_FLAGS_O[`PMLR_BIT_BUS_LO])
    else $error("bus under flag missing");

  chk_step_follows: assert property (
    CE_I && SHUNT_RANGE_SELECT_I |=> SHUNT_STEP_NV_O == `PMLR_STEP_NARROW_NV)
    else $error("narrow range step weight wrong");

  chk_idle_stable: assert property (
    !meas_take && !ALERT_LATCH_MODE_I |=> $stable(DIAG_FLAGS_O[7:2]))
    else $error("flags moved without a new result");

  // One check per comparison, fed from raw inputs rather than the comparator
  chk_shunt_under_flag: assert property (
    meas_take && $signed(shunt_low_level_r) > $signed(SHUNT_MEAS_I)
    |=> DIAG_FLAGS_O[`PMLR_BIT_SHUNT_LO])
    else $error("shunt under flag missing");

  chk_heat_over_flag: assert property (
    meas_take && $signed(DIE_HEAT_READING_I) > $signed(heat_high_level_r)
    |=> DIAG_FLAGS_O[`PMLR_BIT_HEAT_HI])
    else $error("heat over flag missing");

  chk_bus_over_flag: assert property (
    meas_take && BUS_MEAS_I > {1'b0, bus_high_level_r}
    |=> DIAG_FLAGS_O[`PMLR_BIT_BUS_HI])
    else $error("bus over flag missing");

  // Equality must not trip; power above the scaled reset level 0xFFFF00 still trips the flag
  chk_watt_at_level: assert property (
    meas_take && !ALERT_LATCH_MODE_I
    && 32'(POWER_MEAS_I) == {8'h00, watt_high_level_r, 8'h00}
    |=> !DIAG_FLAGS_O[`PMLR_BIT_WATT_HI])
    else $error("power flag set at equal level");

  chk_transparent_clear: assert property (
    meas_take && !ALERT_LATCH_MODE_I
    && $signed(SHUNT_MEAS_I) <= $signed(shunt_high_level_r)
    |=> !DIAG_FLAGS_O[`PMLR_BIT_SHUNT_HI])
    else $error("shunt over flag stayed without a trip");

  chk_shunt_write: assert property (
    wr_en && reg_sel == pmlr_pkg::REG_SHUNT_HI
    |=> shunt_high_level_r == $past(REG_WDATA_I))
    else $error("shunt over level write lost");

  chk_result_counted: assert property (
    meas_take |=> DIAG_FLAGS_O[`PMLR_BIT_CONV_DONE])
    else $error("conversion done flag missing");

  // Clock enable low freezes every register, a pending checksum error too
  chk_freeze_holds: assert property (
    !CE_I |=> $stable(shunt_high_level_r) && $stable(limit_flags_r) && $stable(rdata_r)
    && $stable(trim_ok_r))
    else $error("state moved while clock enable was low");

  cov_shunt_trip: cover property (meas_take && cmp_hits[4]);
  cov_latched_clear: cover property (limit_clear && limit_flags_r != 6'h00);
  cov_trim_fail: cover property ($fell(trim_ok_r));
  cov_set_on_clear: cover property (limit_clear && meas_take && cmp_hits != 6'h00);
  cov_frozen_result: cover property (!CE_I && MEAS_VALID_I);

endmodule

// ==== dv/pmlr_host.sv ====
`timescale 1ns/10ps

// Host side of the register port: one strobe per request, driven 1 ns after the edge
module pmlr_host (
  input wire logic clk_i,
  input wire logic [15:0] rdata_i,
  output logic [7:0] addr_o,
  output logic [15:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // Idle at time zero; no strobe before the bench releases reset
  initial begin
    addr_o = 8'h00;
    wdata_o = 16'h0000;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end

  // Write: held for one taken edge, then address and data are inverted so stale values never match
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    wdata_o = d;
    wr_o = 1'b1;
    @(posedge clk_i);
    #1;
    wr_o = 1'b0;
    addr_o = ~a;
    wdata_o = ~d;
  endtask

  // Read: answer is registered on the taking edge, so it is settled 1 ns later
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(posedge clk_i);
    #1;
    addr_o = a;
    rd_o = 1'b1;
    @(posedge clk_i);
    #1;
    rd_o = 1'b0;
    addr_o = ~a;
    d = rdata_i;
  endtask
endmodule

// ==== dv/tb_top.sv ====
`timescale 1ns/10ps
`include "pmlr_map.svh"

// Self-checking bench for the limit register bank
module tb_top;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // Dropped only by the freeze scenario
  localparam logic [15:0] maker_code_exp = 16'h5A3C; // Arbitrary neutral maker code
  logic mv = 1'b0;
  logic [15:0] sh = 16'h0000;
  logic [15:0] bu = 16'h0000;
  logic [11:0] ht = 12'h000;
  logic [23:0] pw = 24'h000000;
  logic rsel = 1'b0;
  logic latch = 1'b0;
  logic terr = 1'b0;
  logic [7:0] addr;
  logic [15:0] wdata;
  logic wr;
  logic rd;
  logic [15:0] rdata;
  logic [7:0] flags;
  logic [15:0] step;
  int error_cnt = 0;
  int num_checks = 0;

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end

  pmlr_top #(.PWR_W(24), .MAKER_CODE(maker_code_exp)) pmlr_top_inst (.SYS_CLK_I(clk),
    .RST_I(rst), .CE_I(ce), .REG_ADDR_I(addr),
    .REG_WDATA_I(wdata), .REG_WR_I(wr), .REG_RD_I(rd), .REG_RDATA_O(rdata),
    .MEAS_VALID_I(mv), .SHUNT_MEAS_I(sh), .BUS_MEAS_I(bu), .DIE_HEAT_READING_I(ht),
    .POWER_MEAS_I(pw), .SHUNT_RANGE_SELECT_I(rsel), .ALERT_LATCH_MODE_I(latch),
    .TRIM_CSUM_ERR_I(terr), .DIAG_FLAGS_O(flags), .SHUNT_STEP_NV_O(step));

  pmlr_host pmlr_host_inst (.clk_i(clk), .rdata_i(rdata), .addr_o(addr), .wdata_o(wdata),
    .wr_o(wr), .rd_o(rd));

  // Compare with case inequality so an unknown never passes
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Read one register and compare
  task automatic rchk(input logic [7:0] a, input logic [15:0] exp);
    logic [15:0] d;
    pmlr_host_inst.rd(a, d);
    chk($sformatf("reg %h", a), exp, d);
  endtask

  // One result strobe; flags have landed 1 ns after the taking edge
  task automatic meas(input logic [15:0] s, input logic [15:0] b, input logic [11:0] h,
                      input logic [23:0] p, input logic [7:0] exp);
    @(posedge clk);
    #1;
    mv = 1'b1;
    sh = s;
    bu = b;
    ht = h;
    pw = p;
    @(posedge clk);
    #1;
    mv = 1'b0;
    sh = ~s;
    chk("flags", {8'h00, exp}, {8'h00, flags});
  endtask

  // Power-on values of every register and output except the read data holding register
  task automatic t_reset_values();
    chk("flags rst", 16'h0001, {8'h00, flags});
    chk("step rst", `PMLR_STEP_WIDE_NV, step);
    rchk(`PMLR_ADDR_SHUNT_HI, 16'h7FFF);
    rchk(`PMLR_ADDR_SHUNT_LO, 16'h8000);
    rchk(`PMLR_ADDR_BUS_HI, 16'h7FFF);
    rchk(`PMLR_ADDR_BUS_LO, 16'h0000);
    rchk(`PMLR_ADDR_HEAT_HI, 16'h7FF0);
    rchk(`PMLR_ADDR_WATT_HI, 16'hFFFF);
    rchk(`PMLR_ADDR_MAKER, maker_code_exp);
  endtask

  // Reserved bits, read-only maker code and an unmapped place
  task automatic t_reserved();
    pmlr_host_inst.wr(`PMLR_ADDR_BUS_HI, 16'hFFFF);
    pmlr_host_inst.wr(`PMLR_ADDR_BUS_LO, 16'h8001);
    pmlr_host_inst.wr(`PMLR_ADDR_HEAT_HI, 16'hFFFF);
    pmlr_host_inst.wr(`PMLR_ADDR_MAKER, ~maker_code_exp);
    pmlr_host_inst.wr(8'h20, 16'h1234);
    rchk(`PMLR_ADDR_BUS_HI, 16'h7FFF);
    rchk(`PMLR_ADDR_BUS_LO, 16'h0001);
    rchk(`PMLR_ADDR_HEAT_HI, 16'hFFF0);
    rchk(`PMLR_ADDR_MAKER, maker_code_exp);
    rchk(8'h20, 16'h0000);
    pmlr_host_inst.wr(`PMLR_ADDR_BUS_LO, 16'h0000);
  endtask

  // Negative shunt levels, the less negative one in the over level, and range weight
  task automatic t_shunt();
    pmlr_host_inst.wr(`PMLR_ADDR_SHUNT_HI, 16'hFFFF);
    pmlr_host_inst.wr(`PMLR_ADDR_SHUNT_LO, 16'hFFFE);
    pmlr_host_inst.wr(`PMLR_ADDR_HEAT_HI, 16'h7FF0);
    meas(16'h0000, 16'h0100, 12'h000, 24'h0, 8'h43);
    meas(16'hFFFE, 16'h0100, 12'h000, 24'h0, 8'h03);
    meas(16'hFFFD, 16'h0100, 12'h000, 24'h0, 8'h23);
    rsel = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    chk("step narrow", `PMLR_STEP_NARROW_NV, step);
    rsel = 1'b0;
    repeat (2) @(posedge clk);
    #1;
    chk("step wide", `PMLR_STEP_WIDE_NV, step);
    pmlr_host_inst.wr(`PMLR_ADDR_SHUNT_HI, 16'h7FFF);
    pmlr_host_inst.wr(`PMLR_ADDR_SHUNT_LO, 16'h8000);
  endtask

  // Bus over, heat and power levels at and just past their boundaries, bus under just past
  task automatic t_limits();
    pmlr_host_inst.wr(`PMLR_ADDR_BUS_HI, 16'h0100);
    pmlr_host_inst.wr(`PMLR_ADDR_BUS_LO, 16'h0080);
    pmlr_host_inst.wr(`PMLR_ADDR_HEAT_HI, 16'h0500);
    pmlr_host_inst.wr(`PMLR_ADDR_WATT_HI, 16'h0002);
    meas(16'h0000, 16'h0100, 12'h050, 24'h000200, 8'h03);
    meas(16'h0000, 16'h0101, 12'h051, 24'h000201, 8'h97);
    meas(16'h0000, 16'h007F, 12'hFFF, 24'h000000, 8'h0B);
    meas(16'h0000, 16'h0100, 12'h000, 24'h000000, 8'h03);
  endtask

  // Latched flags survive a quiet result and clear on a flag read
  task automatic t_latch();
    latch = 1'b1;
    meas(16'h0000, 16'h0101, 12'h051, 24'h0, 8'h93);
    meas(16'h0000, 16'h0100, 12'h000, 24'h0, 8'h93);
    rchk(`PMLR_ADDR_DIAG, 16'h0093);
    chk("flags clr", 16'h0001, {8'h00, flags});
    latch = 1'b0;
  endtask

  // A checksum error drops the trim bit until the next reset
  task automatic t_trim();
    @(posedge clk);
    #1;
    terr = 1'b1;
    @(posedge clk);
    #1;
    terr = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk("trim low", 16'h0000, {15'h0000, flags[0]});
    rchk(`PMLR_ADDR_DIAG, 16'h0000);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk("trim rst", 16'h0001, {15'h0000, flags[0]});
    rchk(`PMLR_ADDR_SHUNT_HI, 16'h7FFF);
  endtask

  // Clock enable low: writes, results and checksum errors are all ignored
  task automatic t_freeze();
    ce = 1'b0;
    terr = 1'b1;
    pmlr_host_inst.wr(`PMLR_ADDR_SHUNT_HI, 16'h0000);
    meas(16'h7FFF, 16'hFFFF, 12'h7FF, 24'hFFFFFF, 8'h01);
    ce = 1'b1;
    terr = 1'b0;
    rchk(`PMLR_ADDR_SHUNT_HI, 16'h7FFF);
    chk("flags thaw", 16'h0001, {8'h00, flags});
  endtask

  // Verdict and end of run
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  // Main sequence after 16 cycles of reset
  initial begin
    repeat (16) @(posedge clk);
    #1;
    rst = 1'b0;
    t_reset_values();
    t_reserved();
    t_shunt();
    t_limits();
    t_latch();
    t_trim();
    t_freeze();
    report_and_stop();
  end

  // Watchdog; a hang counts as a mismatch
  initial begin
    repeat (5000) @(posedge clk);
    error_cnt++;
    $display("MISMATCH watchdog expected done seen hang");
    report_and_stop();
  end
endmodule
